/* hdl/bb_ctrl_defs.vh */
// constants for the baseband configuration and transmit control bank
// Functional notes
// - serial clock rate: /4, /2, undivided
// - divide-by-four halves receive port sample rate
// - new rate applies at next sample clock
// - bidirectional mode returns fast-bus port one reads on command pin
// - symbol pin shows symbol, sample or codec clock
// - disable bits tristate port sync and data
// - bypass bit removes receive symbol delay
// - clock-stop interlock halts serial clock when full while transmit enabled
// - frame-sync interlock pulses until fifo full
// - active-low bit inverts transmit frame sync
// - ram pointers advance on read or write
// - status and clocks routed to interrupt pins
// - auto adjust aligns symbol clock on enable
// - direct write at sample rate switches fir rate
// - direct write feeds fir input directly
// - bypass uses three lsbs as constellation point
// - transmit enable starts transmission
// - ramp linear, sigmoidal, or hard switch
// - coefficient reset restores default coefficients
// - fifo port at four addresses, address gives bits
// - bit nine ramps up or down
// - bit eight sends four symbols outside bypass, else one
// - all control bits reset to zero
// - four-word fifo, nearly full three, nearly empty one
`ifndef BB_CTRL_DEFS_VH
`define BB_CTRL_DEFS_VH
`define OFS_CFG_ONE 8'h00
`define OFS_CFG_TWO 8'h04
`define OFS_IRQ_ROUTE 8'h08
`define OFS_TX_SETUP 8'h0c
`define OFS_FIFO_LO 8'h10
`define OFS_FIFO_HI 8'h1c
`define OFS_STATUS 8'h20
`define RESET_VAL 8'h00
`define CFG1_RATE_HI 7
`define CFG1_RATE_LO 6
`define CFG1_BIDIR 5
`define CFG1_PINSRC_HI 4
`define CFG1_PINSRC_LO 3
`define CFG1_DIS_RD1 2
`define CFG1_DIS_RD2 1
`define CFG1_DIS_RX 0
`define CFG2_RX_BYPASS 7
`define CFG2_CLK_STOP 6
`define CFG2_FS_ILOCK 5
`define CFG2_FS_LOW 4
`define CFG2_AUX_INC_RD 3
`define CFG2_AUX_EN 2
`define CFG2_COEF_INC_RD 1
`define CFG2_COEF_EN 0
`define TX_AUTO_ADJ 7
`define TX_DW_RATE 6
`define TX_DW_EN 5
`define TX_MOD_BYP 4
`define TX_EN 3
`define TX_RAMP_LIN 2
`define TX_RAMP_EN 1
`define TX_COEF_RST 0
`define RATE_DIV4 2'h0
`define RATE_DIV2 2'h1
`define RATE_DIV1 2'h2
`define PIN_SYMBOL 2'h0
`define PIN_SAMPLE 2'h1
`define PIN_CODEC 2'h2
`define RAMP_STEPS 8'h10
`endif

/* hdl/tx_word_fifo.v */
// four-word transmit fifo with level flags
`timescale 1ns/1ns
module tx_word_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire srst,
    input wire wr_valid,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_ready,
    output wire rd_valid,
    output reg [WIDTH-1:0] rd_data,
    output wire full,
    output wire empty,
    output wire nearly_full,
    output wire nearly_empty,
    output reg overwrite_flag,
    output reg underread_flag,
    input wire flag_clear
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] rp_reg;
    reg [AW:0] cnt_reg;
    wire do_wr;
    wire do_rd;
    integer i;

    assign full = (cnt_reg == DEPTH);
    assign empty = (cnt_reg == {(AW+1){1'b0}});
    assign nearly_full = (cnt_reg == DEPTH - 1);
    assign nearly_empty = (cnt_reg == 1);
    assign rd_valid = !empty;
    assign do_wr = wr_valid && !full;
    assign do_rd = rd_ready && !empty;

    always @* begin
        rd_data = mem[rp_reg];
    end

    always @(posedge clk) begin
        if (srst) begin
            wp_reg <= {AW{1'b0}};
            rp_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            overwrite_flag <= 1'b0;
            underread_flag <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                mem[wp_reg] <= wr_data;
                wp_reg <= wp_reg + 1'b1;
            end
            if (do_rd)
                rp_reg <= rp_reg + 1'b1;
            if (do_wr && !do_rd)
                cnt_reg <= cnt_reg + 1'b1;
            else if (do_rd && !do_wr)
                cnt_reg <= cnt_reg - 1'b1;
            // set wins over clear
            if (wr_valid && full)
                overwrite_flag <= 1'b1;
            else if (flag_clear)
                overwrite_flag <= 1'b0;
            if (rd_ready && empty)
                underread_flag <= 1'b1;
            else if (flag_clear)
                underread_flag <= 1'b0;
        end
    end
endmodule // tx_word_fifo

/* hdl/rate_divider.v */
// programmable enable-pulse divider
`timescale 1ns/1ns
module rate_divider #(
    parameter W = 16
) (
    input wire clk,
    input wire srst,
    input wire run,
    input wire [W-1:0] period,
    output reg tick
);
    reg [W-1:0] cnt_reg;

    always @(posedge clk) begin
        if (srst) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else if (cnt_reg >= period) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // rate_divider

/* hdl/baseband_config_tx_control.v */
// register bank and transmit control of the baseband processor
`timescale 1ns/1ns
`include "bb_ctrl_defs.vh"
module baseband_config_tx_control #(
    parameter SAMPLE_DIV = 16'd1735,
    parameter SYMBOL_DIV = 16'd13888,
    parameter CODEC_DIV = 16'd31249
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire status_one_irq,
    input wire status_two_irq,
    input wire status_three_irq,
    input wire port_one_read_req,
    input wire port_one_is_fast_bus,
    input wire ram_read,
    input wire ram_write,
    input wire [7:0] direct_sample,
    input wire direct_sample_valid,
    output reg serial_clk_en,
    output reg rx_send_en,
    output reg symbol_timing_pin,
    output reg interrupt_pin_one_n,
    output reg interrupt_pin_two_n,
    output reg transmit_frame_sync_pin,
    output reg transmit_frame_sync_oe,
    output reg read_one_sync_oe,
    output reg read_two_sync_oe,
    output reg rx_port_oe,
    output reg port_one_command_data_oe,
    output reg rx_delay_enable,
    output reg [7:0] aux_ptr,
    output reg [7:0] coef_ptr,
    output reg coef_default_load,
    output reg fir_at_sample_rate,
    output reg [7:0] fir_input,
    output reg fir_input_valid,
    output reg [2:0] tx_point,
    output reg [1:0] tx_symbol,
    output reg tx_symbol_valid,
    output reg [7:0] tx_amplitude,
    output reg tx_active
);
    reg [7:0] cfg_one_reg;
    reg [7:0] cfg_two_reg;
    reg [7:0] irq_route_reg;
    reg [7:0] tx_setup_reg;
    reg [1:0] rate_reg;
    reg [1:0] div_reg;
    reg half_reg;
    reg [9:0] word_reg;
    reg [1:0] sym_idx_reg;
    reg [1:0] sym_left_reg;
    reg [1:0] state_reg;
    reg [7:0] ramp_reg;
    reg tx_en_d_reg;
    reg sym_align_reg;
    wire sample_tick;
    wire symbol_tick;
    wire codec_tick;
    wire symbol_tick_raw;
    wire fifo_wr;
    wire fifo_rd;
    wire [9:0] fifo_word;
    wire fifo_valid;
    wire fifo_full;
    wire fifo_empty;
    wire fifo_nf;
    wire fifo_ne;
    wire fifo_ovw;
    wire fifo_und;
    wire wr_access;
    wire rd_access;
    wire fifo_addr;
    wire tx_en;
    wire [7:0] status_val;

    localparam ST_IDLE = 2'h0;
    localparam ST_UP = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam ST_DOWN = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign fifo_addr = (paddr >= `OFS_FIFO_LO) && (paddr <= `OFS_FIFO_HI);
    assign tx_en = tx_setup_reg[`TX_EN];
    assign fifo_wr = wr_access && fifo_addr && (paddr[1:0] == 2'h0);
    assign status_val = {tx_active, fifo_und, fifo_ovw, !fifo_full,
                         fifo_nf, fifo_ne, fifo_empty, 1'b0};

    always @(posedge clk) begin
        if (srst) begin
            cfg_one_reg <= `RESET_VAL;
            cfg_two_reg <= `RESET_VAL;
            irq_route_reg <= `RESET_VAL;
            tx_setup_reg <= `RESET_VAL;
        end else if (wr_access) begin
            if (paddr == `OFS_CFG_ONE)
                cfg_one_reg <= pwdata[7:0];
            else if (paddr == `OFS_CFG_TWO)
                cfg_two_reg <= pwdata[7:0];
            else if (paddr == `OFS_IRQ_ROUTE)
                irq_route_reg <= pwdata[7:0];
            else if (paddr == `OFS_TX_SETUP)
                tx_setup_reg <= pwdata[7:0];
        end
    end

    // fifo port reads as zero and touches nothing
    always @* begin
        if (paddr == `OFS_CFG_ONE)
            prdata = {24'h000000, cfg_one_reg};
        else if (paddr == `OFS_CFG_TWO)
            prdata = {24'h000000, cfg_two_reg};
        else if (paddr == `OFS_IRQ_ROUTE)
            prdata = {24'h000000, irq_route_reg};
        else if (paddr == `OFS_TX_SETUP)
            prdata = {24'h000000, tx_setup_reg};
        else if (paddr == `OFS_STATUS)
            prdata = {24'h000000, status_val};
        else
            prdata = 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////
    // timing enables
    rate_divider #(.W(16)) u_sample (
        .clk(clk), .srst(srst), .run(1'b1), .period(SAMPLE_DIV), .tick(sample_tick)
    );
    rate_divider #(.W(16)) u_symbol (
        .clk(clk), .srst(srst), .run(!sym_align_reg), .period(SYMBOL_DIV),
        .tick(symbol_tick_raw)
    );
    rate_divider #(.W(16)) u_codec (
        .clk(clk), .srst(srst), .run(1'b1), .period(CODEC_DIV), .tick(codec_tick)
    );
    // auto adjust: hold symbol divider count, first symbol on next sample clock
    assign symbol_tick = symbol_tick_raw || (sym_align_reg && sample_tick);

    always @(posedge clk) begin
        if (srst) begin
            tx_en_d_reg <= 1'b0;
            sym_align_reg <= 1'b0;
        end else begin
            tx_en_d_reg <= tx_en;
            if (tx_en && !tx_en_d_reg && tx_setup_reg[`TX_AUTO_ADJ])
                sym_align_reg <= 1'b1;
            else if (sample_tick)
                sym_align_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial clock rate and receive port pacing
    always @(posedge clk) begin
        if (srst) begin
            rate_reg <= `RATE_DIV4;
            div_reg <= 2'h0;
            half_reg <= 1'b0;
            serial_clk_en <= 1'b0;
            rx_send_en <= 1'b0;
        end else begin
            if (sample_tick)
                rate_reg <= cfg_one_reg[`CFG1_RATE_HI:`CFG1_RATE_LO];
            div_reg <= div_reg + 2'h1;
            if (cfg_two_reg[`CFG2_CLK_STOP] && tx_en && fifo_full)
                serial_clk_en <= 1'b0;
            else if (rate_reg == `RATE_DIV4)
                serial_clk_en <= (div_reg == 2'h3);
            else if (rate_reg == `RATE_DIV2)
                serial_clk_en <= div_reg[0];
            else if (rate_reg == `RATE_DIV1)
                serial_clk_en <= 1'b1;
            else
                serial_clk_en <= 1'b0;
            if (sample_tick)
                half_reg <= !half_reg;
            rx_send_en <= sample_tick && ((rate_reg != `RATE_DIV4) || half_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins and routing
    always @(posedge clk) begin
        if (srst) begin
            symbol_timing_pin <= 1'b0;
            interrupt_pin_one_n <= 1'b1;
            interrupt_pin_two_n <= 1'b1;
            transmit_frame_sync_pin <= 1'b0;
            transmit_frame_sync_oe <= 1'b0;
            read_one_sync_oe <= 1'b0;
            read_two_sync_oe <= 1'b0;
            rx_port_oe <= 1'b0;
            port_one_command_data_oe <= 1'b0;
            rx_delay_enable <= 1'b1;
            coef_default_load <= 1'b0;
            fir_at_sample_rate <= 1'b0;
        end else begin
            case (cfg_one_reg[`CFG1_PINSRC_HI:`CFG1_PINSRC_LO])
                `PIN_SYMBOL: symbol_timing_pin <= symbol_tick;
                `PIN_SAMPLE: symbol_timing_pin <= sample_tick;
                `PIN_CODEC: symbol_timing_pin <= codec_tick;
                default: symbol_timing_pin <= 1'b0;
            endcase
            interrupt_pin_one_n <= !((irq_route_reg[0] && status_one_irq) ||
                (irq_route_reg[1] && status_two_irq) ||
                (irq_route_reg[2] && status_three_irq) ||
                (irq_route_reg[3] && sample_tick));
            interrupt_pin_two_n <= !((irq_route_reg[4] && status_one_irq) ||
                (irq_route_reg[5] && status_two_irq) ||
                (irq_route_reg[6] && status_three_irq) ||
                (irq_route_reg[7] && codec_tick));
            // interlock: frame syncs only while fifo has room
            transmit_frame_sync_pin <= cfg_two_reg[`CFG2_FS_LOW] ^
                (symbol_tick && !(cfg_two_reg[`CFG2_FS_ILOCK] && fifo_full));
            transmit_frame_sync_oe <= 1'b1;
            read_one_sync_oe <= !cfg_one_reg[`CFG1_DIS_RD1];
            read_two_sync_oe <= !cfg_one_reg[`CFG1_DIS_RD2];
            rx_port_oe <= !cfg_one_reg[`CFG1_DIS_RX];
            port_one_command_data_oe <= cfg_one_reg[`CFG1_BIDIR] && port_one_is_fast_bus &&
                port_one_read_req;
            rx_delay_enable <= !cfg_two_reg[`CFG2_RX_BYPASS];
            coef_default_load <= tx_setup_reg[`TX_COEF_RST];
            fir_at_sample_rate <= tx_setup_reg[`TX_DW_RATE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ram access pointers
    always @(posedge clk) begin
        if (srst) begin
            aux_ptr <= 8'h00;
            coef_ptr <= 8'h00;
        end else begin
            if (cfg_two_reg[`CFG2_AUX_EN] && (cfg_two_reg[`CFG2_AUX_INC_RD] ? ram_read : ram_write))
                aux_ptr <= aux_ptr + 8'h01;
            if (cfg_two_reg[`CFG2_COEF_EN] &&
                (cfg_two_reg[`CFG2_COEF_INC_RD] ? ram_read : ram_write))
                coef_ptr <= coef_ptr + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit fifo and symbol sequencer
    tx_word_fifo #(.WIDTH(10), .DEPTH(4), .AW(2)) u_fifo (
        .clk(clk), .srst(srst),
        .wr_valid(fifo_wr),
        .wr_data({paddr[3:2], pwdata[7:0]}),
        .rd_ready(fifo_rd), .rd_valid(fifo_valid), .rd_data(fifo_word),
        .full(fifo_full), .empty(fifo_empty), .nearly_full(fifo_nf), .nearly_empty(fifo_ne),
        .overwrite_flag(fifo_ovw), .underread_flag(fifo_und),
        .flag_clear(rd_access && (paddr == `OFS_STATUS))
    );

    assign fifo_rd = tx_en && symbol_tick && (sym_left_reg == 2'h0) && fifo_valid &&
        !tx_setup_reg[`TX_DW_EN];

    always @(posedge clk) begin
        if (srst) begin
            word_reg <= 10'h000;
            sym_idx_reg <= 2'h0;
            sym_left_reg <= 2'h0;
            state_reg <= ST_IDLE;
            ramp_reg <= 8'h00;
            tx_point <= 3'h0;
            tx_symbol <= 2'h0;
            tx_symbol_valid <= 1'b0;
            tx_amplitude <= 8'h00;
            tx_active <= 1'b0;
            fir_input <= 8'h00;
            fir_input_valid <= 1'b0;
        end else begin
            tx_symbol_valid <= 1'b0;
            fir_input_valid <= tx_en && tx_setup_reg[`TX_DW_EN] && direct_sample_valid;
            if (direct_sample_valid)
                fir_input <= direct_sample;
            if (fifo_rd) begin
                word_reg <= fifo_word;
                tx_symbol_valid <= 1'b1;
                tx_point <= fifo_word[2:0];
                tx_symbol <= fifo_word[1:0];
                sym_idx_reg <= 2'h1;
                sym_left_reg <= (!tx_setup_reg[`TX_MOD_BYP] && fifo_word[8]) ? 2'h3 : 2'h0;
                if (fifo_word[9]) begin
                    state_reg <= ST_UP;
                    tx_active <= 1'b1;
                end else if (state_reg != ST_IDLE)
                    state_reg <= ST_DOWN;
            end else if (tx_en && symbol_tick && (sym_left_reg != 2'h0)) begin
                tx_symbol_valid <= 1'b1;
                tx_symbol <= word_reg[{sym_idx_reg, 1'b0} +: 2];
                sym_idx_reg <= sym_idx_reg + 2'h1;
                sym_left_reg <= sym_left_reg - 2'h1;
            end
            case (state_reg)
                ST_IDLE: ramp_reg <= 8'h00;
                ST_UP: begin
                    if (!tx_setup_reg[`TX_RAMP_EN] || ramp_reg == `RAMP_STEPS) begin
                        ramp_reg <= `RAMP_STEPS;
                        // a word taken this cycle decides the state
                        if (!fifo_rd)
                            state_reg <= ST_RUN;
                    end else if (sample_tick)
                        ramp_reg <= ramp_reg + 8'h01;
                end
                ST_RUN: ramp_reg <= `RAMP_STEPS;
                ST_DOWN: begin
                    if (!tx_setup_reg[`TX_RAMP_EN] || ramp_reg == 8'h00) begin
                        ramp_reg <= 8'h00;
                        if (!fifo_rd) begin
                            state_reg <= ST_IDLE;
                            tx_active <= 1'b0;
                        end
                    end else if (sample_tick)
                        ramp_reg <= ramp_reg - 8'h01;
                end
                default: state_reg <= ST_IDLE;
            endcase
            // linear steps, or a smoothed s-curve
            if (tx_setup_reg[`TX_RAMP_LIN] || !tx_setup_reg[`TX_RAMP_EN])
                tx_amplitude <= (ramp_reg >= `RAMP_STEPS) ? 8'hff :
                    {ramp_reg[3:0], 4'h0};
            else if (ramp_reg < 8'h08)
                tx_amplitude <= (ramp_reg * ramp_reg) << 1;
            else
                tx_amplitude <= 8'hff - (((`RAMP_STEPS - ramp_reg) * (`RAMP_STEPS - ramp_reg)) << 1);
        end
    end
endmodule // baseband_config_tx_control

/* tb/host_port_model.sv */
// host-side model: status request levels and ram access strobes
`timescale 1ns/1ns
module host_port_model (
    input wire clk,
    output logic status_one_irq = 1'b0,
    output logic status_two_irq = 1'b0,
    output logic status_three_irq = 1'b0,
    output logic ram_read = 1'b0,
    output logic ram_write = 1'b0
);
    task levels(input logic [2:0] s);
        @(posedge clk);
        {status_three_irq, status_two_irq, status_one_irq} <= s;
    endtask
    // one strobe per access, released on the next edge
    task ram(input logic rd);
        @(posedge clk);
        ram_read <= rd;
        ram_write <= !rd;
        @(posedge clk);
        ram_read <= 1'b0;
        ram_write <= 1'b0;
    endtask
endmodule // host_port_model

/* tb/bb_ctrl_asserts.sv */
// port assertions for the baseband control bank
`timescale 1ns/1ns
`include "bb_ctrl_defs.vh"
module bb_ctrl_asserts #(
    parameter SAMPLE_DIV = 16'd1735
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire ram_read,
    input wire ram_write,
    input wire serial_clk_en,
    input wire rx_port_oe,
    input wire rx_delay_enable,
    input wire [7:0] coef_ptr,
    input wire coef_default_load,
    input wire fir_at_sample_rate,
    input wire tx_active
);
    reg [7:0] cfg1_sh, cfg2_sh, setup_sh;
    reg [15:0] quiet;
    wire wr_hit = psel && penable && pwrite && paddr < `OFS_FIFO_LO;
    wire calm = quiet > 16'd3;
    wire settled = quiet > SAMPLE_DIV + 16'd4;
    // shadow of written control bytes, cycles since last write
    always @(posedge clk) begin
        if (srst) begin
            cfg1_sh <= 8'h00;
            cfg2_sh <= 8'h00;
            setup_sh <= 8'h00;
            quiet <= 16'h0000;
        end else begin
            quiet <= wr_hit ? 16'h0000 : quiet + {15'h0000, ~&quiet};
            if (wr_hit && paddr == `OFS_CFG_ONE) cfg1_sh <= pwdata[7:0];
            if (wr_hit && paddr == `OFS_CFG_TWO) cfg2_sh <= pwdata[7:0];
            if (wr_hit && paddr == `OFS_TX_SETUP) setup_sh <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_RESET_CLEARS: assert property ($fell(srst) |-> !tx_active && coef_ptr == 8'h00)
        else $error("outputs not cleared by reset");
    AST_RX_TRISTATE: assert property (calm && cfg1_sh[`CFG1_DIS_RX] |-> !rx_port_oe)
        else $error("receive port driven while disabled");
    AST_RX_DELAY: assert property (calm |-> rx_delay_enable == !cfg2_sh[`CFG2_RX_BYPASS])
        else $error("receive delay does not follow bypass bit");
    AST_COEF_RESET: assert property (calm |-> coef_default_load == setup_sh[`TX_COEF_RST])
        else $error("coefficient reset does not follow setup");
    AST_FIR_RATE: assert property (calm |-> fir_at_sample_rate == setup_sh[`TX_DW_RATE])
        else $error("fir rate does not follow setup");
    AST_PTR_STEP: assert property (calm && cfg2_sh[1:0] == 2'h3 && ram_read && !ram_write
        |=> coef_ptr == $past(coef_ptr) + 8'h01) else $error("pointer missed read step");
    AST_PTR_HOLD: assert property (calm && cfg2_sh[1:0] == 2'h1 && ram_read && !ram_write
        |=> $stable(coef_ptr)) else $error("pointer stepped on read");
    AST_SERIAL_DIV4: assert property (settled && cfg1_sh[7:6] == `RATE_DIV4
        && !cfg2_sh[`CFG2_CLK_STOP] && serial_clk_en |=> !serial_clk_en [*3] ##1 serial_clk_en)
        else $error("serial clock not divided by four");
    COV_FIFO_WR: cover property (wr_hit == 1'b0 && psel && penable && pwrite && paddr[4]);
    COV_TX_DONE: cover property ($fell(tx_active));
    COV_PTR_STEP: cover property (calm && cfg2_sh[1:0] == 2'h3 && ram_read);
endmodule // bb_ctrl_asserts
bind baseband_config_tx_control bb_ctrl_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) chk_i (.*);

/* tb/tb_top.sv */
// self-checking bench for the baseband control bank
`timescale 1ns/1ns
`include "bb_ctrl_defs.vh"
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic port_one_read_req = 1'b0;
    logic port_one_is_fast_bus = 1'b0;
    logic [7:0] direct_sample = 8'h00;
    logic direct_sample_valid = 1'b0;
    wire pready, pslverr, serial_clk_en, rx_send_en, symbol_timing_pin, rx_port_oe;
    wire interrupt_pin_one_n, interrupt_pin_two_n, transmit_frame_sync_pin, tx_active;
    wire transmit_frame_sync_oe, read_one_sync_oe, read_two_sync_oe, rx_delay_enable;
    wire port_one_command_data_oe, coef_default_load, fir_at_sample_rate, fir_input_valid;
    wire tx_symbol_valid, status_one_irq, status_two_irq, status_three_irq, ram_read, ram_write;
    wire [31:0] prdata;
    wire [7:0] aux_ptr, coef_ptr, fir_input, tx_amplitude;
    wire [2:0] tx_point;
    wire [1:0] tx_symbol;
    logic [31:0] rd;
    logic [7:0] v, pa, pc;
    logic [7:0] pts [4];
    logic [2:0] ptq [$];
    logic [1:0] symq [$];
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24};
    logic [7:0] rw_mask [4] = '{8'h3f, 8'hbf, 8'hff, 8'h87};
    logic [1:0] exp_sym [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    int num_errors = 0;
    int compares = 0;
    int nc, nr, ns;
    baseband_config_tx_control #(.SAMPLE_DIV(16'd7), .SYMBOL_DIV(16'd31), .CODEC_DIV(16'd63)) dut (.*);
    host_port_model host (.*);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (tx_symbol_valid === 1'b1) begin
            ptq.push_back(tx_point);
            symq.push_back(tx_symbol);
        end
    end
    task close_out;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            close_out;
        end
    endtask
    function logic [31:0] exp_status(input int lvl, input logic ovw);
        return {26'h0, ovw, lvl < 4, lvl == 3, lvl == 1, lvl == 0, 1'b0};
    endfunction
    // wait for symbols (kind 0) or for transmit to go idle
    task wait_for(input int kind, input int need);
        int n;
        n = 0;
        while ((kind == 0 ? symq.size() < need : tx_active !== 1'b0) && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) begin
            num_errors++;
            close_out;
        end
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(86111));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset test end");
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            v = v & rw_mask[i % 4];
            apb(1'b1, ra[i % 4], {24'h0, v});
            apb(1'b0, ra[i % 4], 32'h0);
            chk(rd, {24'h0, v});
            repeat (12) @(posedge clk);
        end
        $display("access test end");
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, `OFS_CFG_ONE, 32'((r << 6) | (r << 3)));
            repeat (12) @(posedge clk);
            {nc, nr, ns} = '0;
            repeat (64) begin
                @(posedge clk);
                nc += serial_clk_en;
                nr += rx_send_en;
                ns += symbol_timing_pin;
            end
            chk(nc, 16 << r);
            chk(nr, r ? 8 : 4);
            chk(ns, r == 0 ? 2 : (r == 1 ? 8 : 1));
        end
        $display("rate test end");
        for (int i = 0; i < 8; i++) begin
            host.levels(3'($urandom));
            v = $urandom;
            v = v & 8'h77;
            apb(1'b1, `OFS_IRQ_ROUTE, {24'h0, v});
            repeat (4) @(posedge clk);
            chk({interrupt_pin_two_n, interrupt_pin_one_n},
                {~|(v[6:4] & {status_three_irq, status_two_irq, status_one_irq}),
                ~|(v[2:0] & {status_three_irq, status_two_irq, status_one_irq})});
        end
        $display("routing test end");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `OFS_CFG_TWO, m ? 32'h0f : 32'h05);
            for (int r = 0; r < 2; r++) begin
                pa = aux_ptr;
                pc = coef_ptr;
                host.ram(r[0]);
                repeat (3) @(posedge clk);
                chk({aux_ptr, coef_ptr}, {pa + 8'(r == m), pc + 8'(r == m)});
            end
        end
        $display("pointer test end");
        apb(1'b1, `OFS_CFG_TWO, 32'h0);
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, `OFS_STATUS, 32'h0);
            chk(rd & 32'h3e, exp_status(k > 4 ? 4 : k, k == 5));
            if (k < 4)
                pts[k] = $urandom & 8'h07;
            if (k < 5)
                apb(1'b1, k < 3 ? 8'h18 : 8'h10, {24'h0, pts[k > 3 ? 3 : k]});
        end
        apb(1'b0, `OFS_FIFO_LO, 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd & 32'h3e, exp_status(4, 1'b0));
        apb(1'b1, `OFS_TX_SETUP, 32'h18);
        wait_for(0, 3);
        for (int k = 0; k < 3; k++)
            chk(ptq[k], pts[k]);
        wait_for(1, 0);
        chk(tx_amplitude, 8'h00);
        apb(1'b1, `OFS_TX_SETUP, 32'h0);
        $display("bypass test end");
        symq.delete();
        apb(1'b1, 8'h1c, 32'he4);
        apb(1'b1, 8'h18, 32'h1b);
        apb(1'b1, 8'h10, 32'h00);
        apb(1'b1, `OFS_TX_SETUP, 32'h8e);
        wait_for(0, 5);
        for (int k = 0; k < 5; k++)
            chk(symq[k], exp_sym[k]);
        wait_for(1, 0);
        chk(tx_amplitude, 8'h00);
        apb(1'b1, `OFS_TX_SETUP, 32'h0);
        $display("symbol test end");
        close_out;
    end
endmodule // tb_top
